// *** qbsd_core.sv ***
// quad-bank synchronous dram command interface, device side, with its storage
// assumes a controller on the same clock; clock_gate_input is asynchronous
// Behaviour
// - four banks, 2048 rows, 256 columns, 32 bits
// - pins captured on rising clock edge
// - open takes bank and eleven-line row
// - read/write take column; line 10 autocloses
// - close: line 10 all banks, else one
// - mode load latches op-code from address
// - bank_select picks the addressed bank
// - strobe levels decode the command
// - bursts of 1, 2, 4, 8, page; stop
// - burst columns generated internally from start
// - sequential or interleaved column order selectable
// - read latency two or three clocks
// - new column command accepted every cycle
// - burst reads with single-word writes mode
// - stop or close ends a burst
// - auto close after burst without command
// - close one bank while another bursts
// - commanded refresh, self refresh, power-down
// - deselected device ignores commands; a running burst goes on
// - low clock gate freezes bank, burst and read state
// - byte mask gates write lanes, read drivers
`timescale 1ns/1ps
module qbsd_core #(
  parameter int ROW_BITS = qbsd_pkg::ROW_W,
  parameter int COL_BITS = qbsd_pkg::COL_W,
  parameter int QDEPTH   = qbsd_pkg::QUEUE_DEPTH
) (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic                          clock_gate_input,
  input  wire logic                          device_select_n,
  input  wire logic                          row_strobe_n,
  input  wire logic                          col_strobe_n,
  input  wire logic                          write_strobe_n,
  input  wire logic [qbsd_pkg::BANK_W-1:0]   bank_select,
  input  wire logic [qbsd_pkg::ADDR_W-1:0]   address_bus,
  input  wire logic [qbsd_pkg::LANES-1:0]    byte_mask,
  input  wire logic [qbsd_pkg::DATA_W-1:0]   data_lines_in,
  output logic      [qbsd_pkg::DATA_W-1:0]   data_lines_out,
  output logic      [qbsd_pkg::LANES-1:0]    data_lines_oe,
  output logic                               write_queue_ready,
  output logic      [3:0]                    power_mode,
  output logic      [qbsd_pkg::REF_W-1:0]    refresh_count,
  output logic      [(1<<qbsd_pkg::BANK_W)-1:0] bank_open
);
  import qbsd_pkg::*;

  localparam int NBANK = 1 << BANK_W;
  localparam int MW    = BANK_W + ROW_BITS + COL_BITS;
  localparam int QW    = MW + LANES + DATA_W;
  typedef logic [COL_BITS:0] qbsd_len_t;

  // burst length in words; reserved codes fall back to one word
  function automatic qbsd_len_t burst_len(input logic [2:0] code);
    if (code == BL_PAGE) burst_len = qbsd_len_t'(1'b1) << COL_BITS;
    else if (code <= BL_EIGHT) burst_len = qbsd_len_t'(1'b1) << code;
    else burst_len = qbsd_len_t'(1'b1);
  endfunction

  // column of word idx; wraps inside the aligned block of len columns
  function automatic logic [COL_BITS-1:0] burst_col(input logic [COL_BITS-1:0] start,
      input qbsd_len_t idx, input qbsd_len_t len, input logic ilv);
    logic [COL_BITS-1:0] low;
    logic [COL_BITS-1:0] step;
    low       = COL_BITS'(len - 1'b1);
    step      = ilv ? (start ^ COL_BITS'(idx)) : (start + COL_BITS'(idx));
    burst_col = (start & ~low) | (step & low);
  endfunction

  logic                cke_meta_reg, cke_reg;
  logic                clk_ok, cmd_on, col_go, rd_go, wr_go, fetch;
  qbsd_cmd_t           cmd;
  logic [ADDR_W-1:0]   mode_reg, mode_next;
  logic [NBANK-1:0]    open_reg, open_next;
  logic [ROW_BITS-1:0] row_reg [NBANK];
  logic [ROW_BITS-1:0] row_next [NBANK];
  logic                act_reg, act_next, wr_reg, wr_next, ap_reg, ap_next;
  logic                ilv_reg, ilv_next;
  logic [BANK_W-1:0]   bank_reg, bank_next;
  logic [ROW_BITS-1:0] brow_reg, brow_next;
  logic [COL_BITS-1:0] start_reg, start_next, cur_col;
  qbsd_len_t           idx_reg, idx_next, len_reg, len_next, blen;
  qbsd_pwr_t           pwr_reg, pwr_next;
  logic [REF_W-1:0]    ref_reg, ref_next, tick_reg, tick_next;
  logic                lastref_reg, lastref_next;
  logic                push;
  logic [QW-1:0]       push_word;
  logic [DATA_W-1:0]   mem_reg [NBANK * (1 << ROW_BITS) * (1 << COL_BITS)];
  logic [DATA_W-1:0]   merged, rd_word;
  logic                q_valid, q_ready;
  logic [QW-1:0]       q_word;
  logic                sval_reg, sval_next, oval_reg, oval_next;
  logic [DATA_W-1:0]   sdat_reg, sdat_next, odat_reg, odat_next;
  logic [LANES-1:0]    mask_reg, mask_next, oe_reg, oe_next;

  // clock gate is asynchronous, so it passes two flops before use; left out of
  // reset so the pair fills during reset and a high gate shows no false power-down
  always_ff @(posedge clock) begin
    cke_meta_reg <= clock_gate_input;
    cke_reg      <= cke_meta_reg;
  end

  // command decode from strobe levels at the rising edge
  assign clk_ok  = cke_reg;
  assign cmd     = qbsd_cmd_t'({row_strobe_n, col_strobe_n, write_strobe_n});
  assign cmd_on  = clk_ok && !device_select_n;
  assign rd_go   = cmd_on && (cmd == QC_READ);
  assign wr_go   = cmd_on && (cmd == QC_WRITE);
  assign col_go  = rd_go || wr_go;
  assign blen    = burst_len(mode_reg[MR_BL_HI:MR_BL_LO]);
  assign cur_col = burst_col(start_reg, idx_reg, len_reg, ilv_reg);

  // bank, burst, mode, refresh and power state
  always_comb begin
    mode_next = mode_reg;
    open_next = open_reg;
    row_next  = row_reg;
    act_next  = act_reg;
    wr_next   = wr_reg;
    ap_next   = ap_reg;
    ilv_next  = ilv_reg;
    bank_next = bank_reg;
    brow_next = brow_reg;
    start_next = start_reg;
    idx_next  = idx_reg;
    len_next  = len_reg;
    ref_next  = ref_reg;
    tick_next = tick_reg;
    lastref_next = lastref_reg;
    pwr_next  = pwr_reg;
    push      = 1'b0;
    push_word = {bank_reg, brow_reg, cur_col, byte_mask, data_lines_in};
    if (clk_ok) begin
      pwr_next  = PW_RUN;
      tick_next = '0;
      // running burst advances one column per valid edge
      if (act_reg) begin
        push     = wr_reg;
        idx_next = idx_reg + 1'b1;
        if (idx_next == len_reg) begin
          act_next = 1'b0;
          if (ap_reg) open_next[bank_reg] = 1'b0;
        end
      end
      if (cmd_on) begin
        lastref_next = (cmd == QC_REFRESH);
        case (cmd)
          QC_MODE: mode_next = address_bus;
          QC_REFRESH: ref_next = ref_reg + 1'b1;
          QC_OPEN: begin
            open_next[bank_select] = 1'b1;
            row_next[bank_select]  = address_bus[ROW_BITS-1:0];
          end
          QC_CLOSE: begin
            // other banks keep bursting while one closes
            if (address_bus[AUTO_CLOSE]) open_next = '0;
            else open_next[bank_select] = 1'b0;
            if (address_bus[AUTO_CLOSE] || bank_select == bank_reg) act_next = 1'b0;
          end
          QC_STOP: act_next = 1'b0;
          QC_READ, QC_WRITE: begin
            // a new column command cuts any burst short
            bank_next  = bank_select;
            brow_next  = row_reg[bank_select];
            start_next = address_bus[COL_BITS-1:0];
            ap_next    = address_bus[AUTO_CLOSE];
            ilv_next   = mode_reg[MR_ILV] && (mode_reg[MR_BL_HI:MR_BL_LO] != BL_PAGE);
            wr_next    = (cmd == QC_WRITE);
            len_next   = (wr_next && mode_reg[MR_WSINGLE]) ? qbsd_len_t'(1'b1) : blen;
            idx_next   = wr_next ? qbsd_len_t'(1'b1) : '0;
            act_next   = idx_next != len_next;
            push       = wr_next;
            push_word  = {bank_select, row_reg[bank_select], start_next, byte_mask,
                          data_lines_in};
            if (!act_next && ap_next) open_next[bank_select] = 1'b0;
          end
          default: ;
        endcase
      end
    end else begin
      // a refresh command just before the gate drops selects self refresh
      if (pwr_reg == PW_RUN) begin
        if (lastref_reg) pwr_next = PW_SELF;
        else if (act_reg) pwr_next = PW_SUSPEND;
        else pwr_next = PW_DOWN;
      end
      if (pwr_reg == PW_SELF) begin
        tick_next = tick_reg + 1'b1;
        if (tick_reg == REF_W'(REF_TICK_CYC - 1)) begin
          tick_next = '0;
          ref_next  = ref_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mode_reg  <= MODE_RESET;
      open_reg  <= '0;
      for (int b = 0; b < NBANK; b++) row_reg[b] <= '0;
      act_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      ap_reg    <= 1'b0;
      ilv_reg   <= 1'b0;
      bank_reg  <= '0;
      brow_reg  <= '0;
      start_reg <= '0;
      idx_reg   <= '0;
      len_reg   <= '0;
      ref_reg   <= '0;
      tick_reg  <= '0;
      lastref_reg <= 1'b0;
      pwr_reg   <= PW_RUN;
    end else begin
      mode_reg  <= mode_next;
      open_reg  <= open_next;
      row_reg   <= row_next;
      act_reg   <= act_next;
      wr_reg    <= wr_next;
      ap_reg    <= ap_next;
      ilv_reg   <= ilv_next;
      bank_reg  <= bank_next;
      brow_reg  <= brow_next;
      start_reg <= start_next;
      idx_reg   <= idx_next;
      len_reg   <= len_next;
      ref_reg   <= ref_next;
      tick_reg  <= tick_next;
      lastref_reg <= lastref_next;
      pwr_reg   <= pwr_next;
    end
  end

  // write words queue up; the array has one port, so reads stall the drain
  assign fetch   = clk_ok && act_reg && !wr_reg;
  assign q_ready = !fetch;
  assign rd_word = mem_reg[{bank_reg, brow_reg, cur_col}];

  qbsd_fifo #(
    .WIDTH (QW),
    .DEPTH (QDEPTH)
  ) u_wq (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (write_queue_ready),
    .in_data   (push_word),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_word)
  );

  // masked lanes keep their old contents
  always_comb begin
    merged = mem_reg[q_word[QW-1 -: MW]];
    for (int l = 0; l < LANES; l++) begin
      if (!q_word[DATA_W + l]) merged[l*LANE_W +: LANE_W] = q_word[l*LANE_W +: LANE_W];
    end
  end

  always_ff @(posedge clock) begin
    if (q_valid && q_ready) mem_reg[q_word[QW-1 -: MW]] <= merged;
  end

  // read pipe: latency two skips the stage, three uses it
  always_comb begin
    sval_next = sval_reg;
    sdat_next = sdat_reg;
    oval_next = oval_reg;
    odat_next = odat_reg;
    mask_next = mask_reg;
    oe_next   = oe_reg;
    if (clk_ok) begin
      sval_next = fetch;
      sdat_next = rd_word;
      mask_next = byte_mask;
      if (mode_reg[MR_CL_HI:MR_CL_LO] == CL_THREE) begin
        oval_next = sval_reg;
        odat_next = sdat_reg;
      end else begin
        oval_next = fetch;
        odat_next = rd_word;
      end
      oe_next = oval_next ? ~mask_reg : '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sval_reg <= 1'b0;
      sdat_reg <= '0;
      oval_reg <= 1'b0;
      odat_reg <= '0;
      mask_reg <= '0;
      oe_reg   <= '0;
    end else begin
      sval_reg <= sval_next;
      sdat_reg <= sdat_next;
      oval_reg <= oval_next;
      odat_reg <= odat_next;
      mask_reg <= mask_next;
      oe_reg   <= oe_next;
    end
  end

  assign data_lines_out = odat_reg;
  assign data_lines_oe  = oe_reg;
  assign power_mode     = pwr_reg;
  assign refresh_count  = ref_reg;
  assign bank_open      = open_reg;

  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);

  sel_hold_a: assert property (device_select_n |=> $stable(mode_reg))
    else $error("mode changed while deselected");
  open_row_a: assert property ((cmd_on && cmd == QC_OPEN) |=> open_reg[$past(bank_select)]
      && row_reg[$past(bank_select)] == ROW_BITS'($past(address_bus)))
    else $error("row open not recorded");
  close_all_a: assert property ((cmd_on && cmd == QC_CLOSE && address_bus[AUTO_CLOSE])
      |=> open_reg == '0) else $error("close-all left a bank open");
  lat_two_a: assert property ((rd_go && mode_reg[MR_CL_HI:MR_CL_LO] != CL_THREE)
      ##1 clk_ok |=> oval_reg) else $error("latency two data late");
  lat_three_a: assert property ((rd_go && mode_reg[MR_CL_HI:MR_CL_LO] == CL_THREE
      && !act_reg) ##1 clk_ok |=> !oval_reg ##0 clk_ok |=> oval_reg)
    else $error("latency three wrong");
  burst_one_a: assert property ((rd_go && blen == qbsd_len_t'(1'b1))
      ##1 (clk_ok && !col_go) |=> !act_reg) else $error("one-word burst ran on");
  single_wr_a: assert property ((wr_go && mode_reg[MR_WSINGLE]) |=> !act_reg)
    else $error("single write became a burst");
  stop_a: assert property ((cmd_on && cmd == QC_STOP) |=> !act_reg)
    else $error("burst stop ignored");
  auto_close_a: assert property ((clk_ok && act_reg && ap_reg
      && (!cmd_on || cmd == QC_NOP) && idx_reg + 1'b1 == len_reg) |=> !open_reg[$past(bank_reg)])
    else $error("auto close missed");
  start_col_a: assert property (rd_go |=> cur_col == COL_BITS'($past(address_bus)))
    else $error("burst did not start at given column");
  ilv_col_a: assert property ((act_reg && ilv_reg && idx_reg == qbsd_len_t'(1'b1))
      |-> cur_col == (start_reg ^ COL_BITS'(1'b1))) else $error("interleave order wrong");
  freeze_a: assert property (!clk_ok |=> $stable(idx_reg) && $stable(open_reg))
    else $error("state moved with clock gate low");
  mask_rd_a: assert property ((clk_ok && byte_mask == '1) ##1 clk_ok |=> data_lines_oe == '0)
    else $error("masked lanes driven on read");
endmodule // qbsd_core

// *** qbsd_ctrl_model.sv ***
// memory controller model: drives command, address, mask and write data pins
// assumes the bench calls issue once per cycle, one command per edge
`timescale 1ns/1ps
module qbsd_ctrl_model (
  input  wire logic                        clock,
  output logic                             device_select_n,
  output logic                             row_strobe_n,
  output logic                             col_strobe_n,
  output logic                             write_strobe_n,
  output logic [qbsd_pkg::BANK_W-1:0]      bank_select,
  output logic [qbsd_pkg::ADDR_W-1:0]      address_bus,
  output logic [qbsd_pkg::LANES-1:0]       byte_mask,
  output logic [qbsd_pkg::DATA_W-1:0]      data_lines_in
);
  import qbsd_pkg::*;
  // idle pins at time zero: deselected nop
  initial begin
    device_select_n = 1'b1;
    {row_strobe_n, col_strobe_n, write_strobe_n} = 3'h7;
    bank_select = 2'h0;
    address_bus = 11'h000;
    byte_mask = 4'h0;
    data_lines_in = 32'h0;
  end
  // driven just after an edge so the next edge takes the whole command
  task automatic issue(input qbsd_cmd_t c, input logic [1:0] b, input logic [10:0] a,
                       input logic [3:0] m, input logic [31:0] d, input logic drv,
                       input logic sel);
    @(posedge clock);
    device_select_n <= sel;
    {row_strobe_n, col_strobe_n, write_strobe_n} <= c;
    bank_select <= b;
    address_bus <= a;
    byte_mask <= m;
    // released data lines flip so a stale word can never pass for fresh data
    data_lines_in <= drv ? d : ~data_lines_in;
  endtask
endmodule // qbsd_ctrl_model

// *** qbsd_fifo.sv ***
// first-in first-out queue with valid and ready on both sides
// assumes one clock, synchronous active-high reset and a power-of-two depth
`timescale 1ns/1ps
module qbsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PW-1:0]    wr_reg, wr_next;
  logic [PW-1:0]    rd_reg, rd_next;
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             rdy_reg, rdy_next;
  logic             take;
  logic             give;

  // a push and a pop in one cycle leave the level unchanged
  always_comb begin
    take     = in_valid && rdy_reg;
    give     = out_ready && (cnt_reg != '0);
    wr_next  = take ? wr_reg + 1'b1 : wr_reg;
    rd_next  = give ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + CW'(take) - CW'(give);
    rdy_next = cnt_next < CW'(DEPTH);
  end

  // ready is registered so the source sees a clean flop, not a compare
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
    if (take) store_reg[wr_reg] <= in_data;
  end

  assign in_ready  = rdy_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data  = store_reg[rd_reg];
endmodule // qbsd_fifo

// *** qbsd_pkg.sv ***
// constants and types shared by the dram command interface and its write queue
// assumes a 200 MHz system clock and an eleven-line address bus from the controller
package qbsd_pkg;
  localparam int BANK_W      = 2;
  localparam int ROW_W       = 11;
  localparam int COL_W       = 8;
  localparam int ADDR_W      = 11;
  localparam int DATA_W      = 32;
  localparam int LANES       = 4;
  localparam int LANE_W      = 8;
  localparam int QUEUE_DEPTH = 8;
  localparam int REF_W       = 12;

  // mode word field positions, latched from the address lines
  localparam int MR_BL_LO   = 0;
  localparam int MR_BL_HI   = 2;
  localparam int MR_ILV     = 3;
  localparam int MR_CL_LO   = 4;
  localparam int MR_CL_HI   = 6;
  localparam int MR_WSINGLE = 9;
  localparam int AUTO_CLOSE = 10;

  localparam logic [2:0]        BL_EIGHT   = 3'h3;
  localparam logic [2:0]        BL_PAGE    = 3'h7;
  localparam logic [2:0]        CL_THREE   = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RESET = 11'h020;

  // self refresh pacing: rows spread evenly over the retention window, rounded down
  localparam int CLOCK_NS      = 5;
  localparam int REF_WINDOW_MS = 64;
  localparam int REF_ROWS      = 4096;
  localparam int NS_PER_MS     = 1000000;
  localparam int REF_TICK_CYC  = (REF_WINDOW_MS * NS_PER_MS) / (CLOCK_NS * REF_ROWS);

  // command code is {row strobe, column strobe, write strobe}, all active low
  typedef enum logic [2:0] {
    QC_MODE    = 3'h0,
    QC_REFRESH = 3'h1,
    QC_CLOSE   = 3'h2,
    QC_OPEN    = 3'h3,
    QC_WRITE   = 3'h4,
    QC_READ    = 3'h5,
    QC_STOP    = 3'h6,
    QC_NOP     = 3'h7
  } qbsd_cmd_t;

  typedef enum logic [3:0] {
    PW_RUN     = 4'h1,
    PW_SUSPEND = 4'h2,
    PW_DOWN    = 4'h4,
    PW_SELF    = 4'h8
  } qbsd_pwr_t;
endpackage

// *** tb.sv ***
// self-checking bench for the dram command interface and the write queue
// assumes the memory shrunk to 4 rows by 16 columns; controller model drives pins
`timescale 1ns/1ps
module tb;
  import qbsd_pkg::*;
  typedef struct packed {
    logic [31:0] w;
    logic [3:0]  oe;
    logic [31:0] at;
  } qbsd_note_t;
  logic        clock, reset, clock_gate_input, device_select_n, write_queue_ready;
  logic        row_strobe_n, col_strobe_n, write_strobe_n, ilv, single;
  logic [1:0]  bank_select;
  logic [10:0] address_bus;
  logic [3:0]  byte_mask, data_lines_oe, power_mode, bank_open;
  logic [31:0] data_lines_in, data_lines_out, cnt, seed;
  logic [11:0] refresh_count;
  int          fail_count, num_checks, blen, lat;
  logic [31:0] mem [logic [7:0]];
  logic [1:0]  open_row [4];
  logic [2:0]  codes [5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
  qbsd_note_t  exp_q [$];
  qbsd_note_t  nt;
  logic [31:0] lm;

  qbsd_core #(.ROW_BITS(2), .COL_BITS(4), .QDEPTH(8)) i_qbsd_core (.clock, .reset,
    .clock_gate_input, .device_select_n, .row_strobe_n, .col_strobe_n, .write_strobe_n,
    .bank_select, .address_bus, .byte_mask, .data_lines_in, .data_lines_out,
    .data_lines_oe, .write_queue_ready, .power_mode, .refresh_count, .bank_open);
  qbsd_ctrl_model i_qbsd_ctrl_model (.clock, .device_select_n, .row_strobe_n,
    .col_strobe_n, .write_strobe_n, .bank_select, .address_bus, .byte_mask, .data_lines_in);

  // 200 MHz clock and an edge counter used to time read words
  always #2.5 clock = ~clock;
  always @(posedge clock) cnt <= cnt + 1;

  task automatic bad(string s);
    fail_count++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] e, string s);
    num_checks++;
    if (got !== e) bad(s);
  endtask
  task automatic give_verdict();
    if (exp_q.size() != 0) bad("read words missing");
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmd(qbsd_cmd_t c, logic [1:0] b, logic [10:0] a, logic [3:0] mk = 4'h0,
                     logic [31:0] d = 32'h0, logic drv = 1'b0, logic sel = 1'b0);
    i_qbsd_ctrl_model.issue(c, b, a, mk, d, drv, sel);
    #1; // outputs settle before the caller looks at them
  endtask
  task automatic idle(int k);
    repeat (k) cmd(QC_NOP, 2'h0, 11'h000);
  endtask
  // bounded wait on power mode (sel 0) or refresh count (sel 1)
  task automatic wait_for(int sel, logic [11:0] e, int lim);
    int k;
    k = 0;
    while ((sel ? refresh_count : {8'h0, power_mode}) !== e && k < lim) begin
      @(posedge clock);
      k++;
    end
    num_checks++;
    if ((sel ? refresh_count : {8'h0, power_mode}) !== e) begin
      bad("state wait ran out");
      give_verdict();
    end
  endtask
  // column of word i: aligned wrap when sequential, xor when interleaved
  function automatic logic [3:0] colx(logic [3:0] s, int i);
    if (ilv) return s ^ i[3:0];
    return 4'((s & ~(blen - 1)) | ((s + i) & (blen - 1)));
  endfunction
  task automatic mode(logic [2:0] bl, logic il, logic [2:0] l, logic sg);
    cmd(QC_MODE, 2'h0, {1'b0, sg, 2'h0, l, il, bl});
    blen = (bl == BL_PAGE) ? 16 : (1 << bl);
    ilv = il && bl != BL_PAGE;
    lat = (l == CL_THREE) ? 3 : 2;
    single = sg;
  endtask
  task automatic open(logic [1:0] b, logic [1:0] r);
    cmd(QC_OPEN, b, {9'h000, r});
    open_row[b] = r;
  endtask
  // write burst; the model keeps only unmasked lanes, one word in single mode
  task automatic wr(logic [1:0] b, logic [3:0] c, logic [3:0] mk, logic ac);
    logic [31:0] d;
    logic [7:0]  k;
    for (int i = 0; i < blen; i++) begin
      d = $random(seed);
      k = {b, open_row[b], colx(c, i)};
      if (i == 0 || !single)
        for (int l = 0; l < 4; l++) if (!mk[l]) mem[k][8*l +: 8] = d[8*l +: 8];
      if (i == 0) cmd(QC_WRITE, b, {ac, 6'h00, c}, mk, d, 1'b1);
      else cmd(QC_NOP, 2'h0, 11'h000, mk, d, 1'b1);
    end
  endtask
  // read: note nw expected words, mask held over the words it governs when pad
  task automatic rd(logic [1:0] b, logic [3:0] c, logic [3:0] mk, logic ac, int nw, bit pad);
    logic [31:0] t;
    cmd(QC_READ, b, {ac, 6'h00, c}, mk);
    t = cnt + lat;
    for (int i = 0; i < nw; i++) exp_q.push_back('{mem[{b, open_row[b], colx(c, i)}], ~mk, t + i});
    if (pad) repeat (nw + lat - 2) cmd(QC_NOP, 2'h0, 11'h000, mk);
  endtask

  // every driven read word is matched to the oldest note: value, lanes and edge
  always @(posedge clock) begin
    if (!reset && data_lines_oe !== 4'h0) begin
      if (exp_q.size() == 0) bad("unexpected read word");
      else begin
        nt = exp_q.pop_front();
        num_checks++;
        for (int l = 0; l < 4; l++) lm[8*l +: 8] = {8{nt.oe[l]}};
        if (data_lines_oe !== nt.oe || cnt !== nt.at || (data_lines_out & lm) !== (nt.w & lm))
          bad("read word mismatch");
      end
    end
  end

  // a hang is cut here and ends in the same report
  initial begin
    #400000;
    bad("run timed out");
    give_verdict();
  end

  initial begin
    seed = 32'h0ff509b7;
    clock = 1'b0;
    cnt = 32'h0;
    reset = 1'b1;
    clock_gate_input = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    idle(3);
    chk(power_mode, 4'h1, "reset power mode");
    chk(bank_open, 4'h0, "reset banks");
    chk(refresh_count, 12'h000, "reset refresh count");
    chk({write_queue_ready, data_lines_oe}, 5'h10, "reset ready or drive");
    // every burst length, both orders, both latencies
    mode(3'h7, 1'b0, 3'h2, 1'b0);
    open(2'h3, 2'h1);
    for (int k = 0; k < 5; k++) begin
      mode(codes[k], k >= 3, 3'(2 + k % 2), 1'b0);
      wr(2'h3, 4'hc, 4'h0, 1'b0);
      idle(20);
      rd(2'h3, 4'hd, 4'h0, k == 4, blen, 1'b1);
      idle(4);
    end
    chk(bank_open, 4'h0, "auto close after read");
    mode(3'h2, 1'b0, 3'h2, 1'b0);
    open(2'h1, 2'h2);
    open(2'h2, 2'h1);
    idle(2);
    chk(bank_open, 4'h6, "open banks");
    wr(2'h1, 4'h4, 4'h0, 1'b0);
    wr(2'h1, 4'h4, 4'h2, 1'b0);
    wr(2'h2, 4'h8, 4'h0, 1'b0);
    idle(16);
    rd(2'h1, 4'h6, 4'h4, 1'b0, 4, 1'b1);
    // bank 1 closes while bank 2 bursts
    rd(2'h2, 4'h8, 4'h0, 1'b0, 4, 1'b0);
    cmd(QC_CLOSE, 2'h1, 11'h000);
    idle(5);
    chk(bank_open, 4'h4, "close beside burst");
    rd(2'h2, 4'h9, 4'h0, 1'b0, 1, 1'b0);
    rd(2'h2, 4'ha, 4'h0, 1'b0, 4, 1'b1);
    // stop after two words: a third word would show as unexpected
    rd(2'h2, 4'h9, 4'h0, 1'b0, 2, 1'b0);
    idle(1);
    cmd(QC_STOP, 2'h2, 11'h000);
    idle(4);
    idle(3);
    mode(3'h2, 1'b0, 3'h2, 1'b1);
    wr(2'h2, 4'h8, 4'h0, 1'b1);
    idle(16);
    chk(bank_open, 4'h0, "auto close single write");
    open(2'h2, open_row[2]);
    idle(1);
    rd(2'h2, 4'h8, 4'h0, 1'b0, 4, 1'b1);
    idle(3);
    open(2'h0, 2'h0);
    open(2'h1, 2'h3);
    cmd(QC_CLOSE, 2'h0, 11'h000);
    idle(2);
    chk(bank_open, 4'h6, "close one bank");
    cmd(QC_CLOSE, 2'h3, 11'h400);
    idle(2);
    chk(bank_open, 4'h0, "close all banks");
    cmd(QC_OPEN, 2'h1, 11'h001, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(2);
    chk(bank_open, 4'h0, "deselected open");
    cmd(QC_REFRESH, 2'h0, 11'h000);
    idle(2);
    chk(refresh_count, 12'h001, "commanded refresh");
    clock_gate_input <= 1'b0;
    wait_for(0, 12'h004, 8);
    cmd(QC_OPEN, 2'h0, 11'h000);
    idle(2);
    chk(bank_open, 4'h0, "gated open");
    clock_gate_input <= 1'b1;
    wait_for(0, 12'h001, 8);
    idle(3);
    cmd(QC_REFRESH, 2'h0, 11'h000);
    clock_gate_input <= 1'b0;
    // deselect at once: a held refresh would count twice before the gate shows low
    cmd(QC_NOP, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
    wait_for(0, 12'h008, 8);
    wait_for(1, 12'h003, 3300);
    clock_gate_input <= 1'b1;
    wait_for(0, 12'h001, 8);
    // write queue through the top: back-to-back bursts, the first unmasked and the rest with random masks, then read back
    mode(3'h3, 1'b0, 3'h3, 1'b0);
    open(2'h0, 2'h2);
    for (int k = 0; k < 4; k++) begin
      wr(2'h0, 4'h3, (k == 0) ? 4'h0 : 4'($random(seed)), 1'b0);
      chk(write_queue_ready, 32'h1, "write queue refused a word");
    end
    idle(4);
    rd(2'h0, 4'h5, 4'h0, 1'b1, 8, 1'b1);
    idle(4);
    chk(bank_open, 4'h0, "auto close after queue read");
    // all lanes masked with the clock running: nothing may be driven
    cmd(QC_NOP, 2'h0, 11'h000, 4'hf);
    idle(4);
    chk({write_queue_ready, data_lines_oe}, 5'h10, "queue idle at end");
    give_verdict();
  end
endmodule // tb
